// ---- verilog/fsr_pkg.sv ----
// Package for the fault status reporting block: map, fault codes, types
// Behaviour
// - Status words 8 bits, read with upper 24 bits zero
// - Status words are read-only to software
// - Word one holds contactor, pot, memory faults
// - Word two holds sequencing, voltage, temperature faults
// - Word three holds overtemperature and driver faults
// - Word four holds precharge, overcurrent, motor faults
// - Word five holds supply, firmware, encoder faults
// - Word six: bits 2,4,6,7 only
// - Word seven: bits 1 to 7 only
// - Word eight: bits 0 to 3 only
// - Two user words, first maps codes 51-58
// - Second user word maps 59, 61-67
// - User fault without actions only blinks
// - Assigned actions follow set user fault bits
// - Each user fault has 16-bit action word
package fsr_pkg;

    localparam int FSR_AW = 12;
    localparam int FSR_SYS_WORDS = 8;
    localparam int FSR_USER_WORDS = 2;
    localparam int FSR_NUM_USER = 16;
    localparam int FSR_NUM_FAULTS = 80;
    localparam int FSR_DIV_W = 24;

    // Register map, byte addresses
    localparam logic [FSR_AW-1:0] FSR_STATUS_BASE = 12'h000;
    localparam logic [FSR_AW-1:0] FSR_USER_BASE = 12'h020;
    localparam logic [FSR_AW-1:0] FSR_ACTION_BASE = 12'h040;
    localparam logic [FSR_AW-1:0] FSR_MAP_END = 12'h080;

    // Implemented bits of each status word, lowest word first
    localparam logic [7:0] FSR_SYS_MASK [FSR_SYS_WORDS] = '{
        8'h0FF, 8'h0DF, 8'h0FF, 8'h0FF, 8'h0FF, 8'h0D4, 8'h0FE, 8'h00F};
    // Bits that exist only on pump variants
    localparam logic [7:0] FSR_PUMP_MASK [FSR_SYS_WORDS] = '{
        8'h000, 8'h000, 8'h000, 8'h000, 8'h000, 8'h080, 8'h000, 8'h007};

    // Blink code per fault index: status words 0..63, user faults 64..79
    localparam logic [7:0] FSR_CODE [FSR_NUM_FAULTS] = '{
        8'h26, 8'h27, 8'h2D, 8'h2A, 8'h29, 8'h2C, 8'h2B, 8'h2E,
        8'h2F, 8'h11, 8'h12, 8'h17, 8'h18, 8'h00, 8'h16, 8'h0F,
        8'h10, 8'h1F, 8'h20, 8'h21, 8'h22, 8'h23, 8'h1F, 8'h20,
        8'h0E, 8'h1A, 8'h1B, 8'h0C, 8'h0D, 8'h1C, 8'h31, 8'h25,
        8'h45, 8'h1D, 8'h44, 8'h19, 8'h47, 8'h48, 8'h24, 8'h49,
        8'h00, 8'h00, 8'h2F, 8'h00, 8'h59, 8'h00, 8'h57, 8'h61,
        8'h00, 8'h5B, 8'h5C, 8'h5D, 8'h5E, 8'h4B, 8'h4A, 8'h62,
        8'h5F, 8'h60, 8'h2F, 8'h63, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39, 8'h3A,
        8'h3B, 8'h3D, 8'h3E, 8'h3F, 8'h40, 8'h41, 8'h42, 8'h43};

    localparam logic [7:0] FSR_RADIX = 8'h0A;

    // Blink timing in ticks of the blink divider
    localparam int FSR_TICK_MS = 250;
    localparam int FSR_CLK_KHZ = 50000;
    localparam int FSR_TICK_CYCLES = FSR_TICK_MS * FSR_CLK_KHZ;
    localparam logic [2:0] FSR_GAP_TICKS = 3'h2;
    localparam logic [2:0] FSR_PAUSE_TICKS = 3'h4;

    typedef enum logic [2:0] {
        BL_SCAN, BL_TENS_ON, BL_TENS_OFF, BL_GAP, BL_ONES_ON, BL_ONES_OFF, BL_PAUSE
    } fsr_blink_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [FSR_AW-1:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } fsr_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } fsr_apb_rsp_t;

    typedef struct packed {
        logic [FSR_SYS_WORDS-1:0][7:0] sys;
        logic [FSR_USER_WORDS-1:0][7:0] user;
        logic [FSR_NUM_USER-1:0][15:0] action;
        logic [15:0] act_out;
        fsr_apb_rsp_t rsp;
        logic [FSR_DIV_W-1:0] div;
        logic tick;
        fsr_blink_t st;
        logic [6:0] idx;
        logic [7:0] code;
        logic [3:0] dig;
        logic [2:0] ph;
        logic led;
    } fsr_state_t;

    function automatic logic [3:0] fsr_tens(input logic [7:0] code);
        fsr_tens = 4'(code / FSR_RADIX);
    endfunction

    function automatic logic [3:0] fsr_ones(input logic [7:0] code);
        fsr_ones = 4'(code % FSR_RADIX);
    endfunction

endpackage

// ---- verilog/fsr_top.sv ----
// Fault status reporting block: APB register bank, action merge, LED blinker
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps
module fsr_top #(
    parameter bit PUMP_VARIANT = 1'b0,
    parameter int TICK_CYCLES = fsr_pkg::FSR_TICK_CYCLES
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire fsr_pkg::fsr_apb_req_t apb_req,
    output fsr_pkg::fsr_apb_rsp_t apb_rsp,
    input wire logic [63:0] fault_detect,
    output logic [15:0] fault_actions,
    output logic led_out,
    output logic [7:0] led_code
);
    import fsr_pkg::*;

    fsr_state_t s;
    fsr_state_t n;

    logic is_status;
    logic is_user;
    logic is_action;
    logic is_bad;
    logic [3:0] word_idx;
    logic [63:0] sys_live;
    logic [FSR_NUM_FAULTS-1:0] active;

    // Address decode, shared by read and write
    always_comb begin
        word_idx = apb_req.paddr[5:2];
        is_status = 1'b0;
        is_user = 1'b0;
        is_action = 1'b0;
        if (apb_req.paddr[1:0] == 2'h0 && apb_req.paddr < FSR_MAP_END) begin
            if (apb_req.paddr >= FSR_ACTION_BASE) begin
                is_action = 1'b1;
            end else if (apb_req.paddr >= FSR_USER_BASE) begin
                is_user = (apb_req.paddr - FSR_USER_BASE) < FSR_AW'(4 * FSR_USER_WORDS);
            end else begin
                is_status = 1'b1;
            end
        end
        is_bad = !(is_status || is_user || is_action);
    end

    // Detected faults with unused and absent pump bits forced low
    always_comb begin
        for (int w = 0; w < FSR_SYS_WORDS; w++) begin
            sys_live[w*8 +: 8] = fault_detect[w*8 +: 8] & FSR_SYS_MASK[w]
                & (PUMP_VARIANT ? 8'hFF : ~FSR_PUMP_MASK[w]);
        end
    end

    assign active = {s.user, s.sys};

    always_comb begin
        logic [15:0] acc;
        logic acc_hit;
        acc = 16'h0000;
        acc_hit = apb_req.psel && apb_req.penable;
        n = s;

        // Status words sample live detection every cycle, bits 0..7 per word
        n.sys = sys_live;

        // Blink tick divider
        n.tick = 1'b0;
        if (s.div == FSR_DIV_W'(TICK_CYCLES - 1)) begin
            n.div = '0;
            n.tick = 1'b1;
        end else begin
            n.div = s.div + 1'b1;
        end

        // APB: one wait state, answer comes from flops
        n.rsp.pready = 1'b0;
        n.rsp.pslverr = 1'b0;
        n.rsp.prdata = 32'h0000_0000;
        if (acc_hit && !s.rsp.pready) begin
            n.rsp.pready = 1'b1;
            n.rsp.pslverr = is_bad;
            if (!apb_req.pwrite) begin
                if (is_status) begin
                    n.rsp.prdata = {24'h00_0000, s.sys[word_idx[2:0]]};
                end else if (is_user) begin
                    n.rsp.prdata = {24'h00_0000, s.user[word_idx[0]]};
                end else if (is_action) begin
                    n.rsp.prdata = {16'h0000, s.action[word_idx]};
                end
            end
        end
        // Writes land on the edge where pready is sampled; status words ignore them
        if (acc_hit && s.rsp.pready && apb_req.pwrite && !is_bad) begin
            if (is_user && apb_req.pstrb[0]) begin
                n.user[word_idx[0]] = apb_req.pwdata[7:0];
            end
            if (is_action) begin
                if (apb_req.pstrb[0]) begin
                    n.action[word_idx][7:0] = apb_req.pwdata[7:0];
                end
                if (apb_req.pstrb[1]) begin
                    n.action[word_idx][15:8] = apb_req.pwdata[15:8];
                end
            end
        end

        // Merge actions of every set user fault; no word set means no action
        for (int i = 0; i < FSR_NUM_USER; i++) begin
            if (s.user[i/8][i%8]) begin
                acc = acc | s.action[i];
            end
        end
        n.act_out = acc;

        // Blinker: tens flashes, gap, ones flashes, pause, then next fault
        case (s.st)
            BL_SCAN: begin
                n.led = 1'b0;
                n.idx = (s.idx == 7'(FSR_NUM_FAULTS - 1)) ? 7'h00 : s.idx + 1'b1;
                if (active == '0) begin
                    n.code = 8'h00;
                end
                if (active[s.idx]) begin
                    n.code = FSR_CODE[s.idx];
                    n.dig = fsr_tens(FSR_CODE[s.idx]);
                    n.st = BL_TENS_ON;
                    n.led = 1'b1;
                end
            end
            BL_TENS_ON, BL_ONES_ON: begin
                if (s.tick) begin
                    n.led = 1'b0;
                    n.dig = s.dig - 1'b1;
                    n.st = (s.st == BL_TENS_ON) ? BL_TENS_OFF : BL_ONES_OFF;
                end
            end
            BL_TENS_OFF: begin
                if (s.tick) begin
                    n.ph = 3'h0;
                    if (s.dig != 4'h0) begin
                        n.led = 1'b1;
                        n.st = BL_TENS_ON;
                    end else begin
                        n.st = BL_GAP;
                    end
                end
            end
            BL_GAP: begin
                if (s.tick) begin
                    n.ph = s.ph + 1'b1;
                    if (s.ph == FSR_GAP_TICKS - 1'b1) begin
                        n.ph = 3'h0;
                        n.dig = fsr_ones(s.code);
                        if (fsr_ones(s.code) == 4'h0) begin
                            n.st = BL_PAUSE;
                        end else begin
                            n.led = 1'b1;
                            n.st = BL_ONES_ON;
                        end
                    end
                end
            end
            BL_ONES_OFF: begin
                if (s.tick) begin
                    n.ph = 3'h0;
                    if (s.dig != 4'h0) begin
                        n.led = 1'b1;
                        n.st = BL_ONES_ON;
                    end else begin
                        n.st = BL_PAUSE;
                    end
                end
            end
            BL_PAUSE: begin
                if (s.tick) begin
                    n.ph = s.ph + 1'b1;
                    if (s.ph == FSR_PAUSE_TICKS - 1'b1) begin
                        n.ph = 3'h0;
                        n.st = BL_SCAN;
                    end
                end
            end
            default: begin
                n.led = 1'b0;
                n.st = BL_SCAN;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign apb_rsp = s.rsp;
    assign fault_actions = s.act_out;
    assign led_out = s.led;
    assign led_code = s.code;

    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    sequence seq_setup;
        apb_req.psel && !apb_req.penable;
    endsequence

    sequence seq_access_first;
        apb_req.psel && apb_req.penable && !s.rsp.pready;
    endsequence

    logic [7:0] status_seen;
    assign status_seen = s.sys[word_idx[2:0]];

    a_apb_one_wait: assert property (seq_setup ##1 seq_access_first |=> s.rsp.pready)
        else $error("APB answer not one cycle after access start");

    a_status_upper_zero: assert property (seq_access_first and (is_status && !apb_req.pwrite)
        |=> s.rsp.prdata[31:8] == 24'h00_0000 && s.rsp.prdata[7:0] == $past(status_seen))
        else $error("Status read returned wrong data");

    // Judge the answer while it stands; the write must be accepted yet leave the word on live detection
    a_status_ro_write: assert property ((apb_req.psel && apb_req.penable && apb_req.pwrite && is_status && s.rsp.pready)
        |-> !s.rsp.pslverr ##1 s.sys == $past(sys_live))
        else $error("Status word changed by a write");

    a_unused_bits_zero: assert property (
        (s.sys[1][5] | s.sys[5][0] | s.sys[5][1] | s.sys[5][3] | s.sys[5][5] | s.sys[6][0]
        | (|s.sys[7][7:4])) == 1'b0)
        else $error("Unused status bit set");

    a_status_tracks: assert property ($changed(fault_detect) |=> s.sys == $past(sys_live))
        else $error("Status word did not follow detection");

    a_user_hold: assert property (!(apb_req.psel && apb_req.penable && apb_req.pwrite && is_user)
        |=> $stable(s.user))
        else $error("User fault changed without a write");

    a_no_action: assert property ((s.user == 16'h0000) [*2] |-> s.act_out == 16'h0000)
        else $error("Action asserted with no user fault set");

    a_action_merge: assert property (s.user[0][0] && s.action[0][3] |=> s.act_out[3])
        else $error("Action of set user fault missing");

    a_blink_load: assert property ((s.st == BL_SCAN) && active[s.idx]
        |=> s.st == BL_TENS_ON && s.led && s.code == FSR_CODE[$past(s.idx)])
        else $error("Blink did not start with fault code");

    a_led_idle: assert property ((s.st == BL_SCAN) && (active == '0) |=> !s.led && s.code == 8'h00)
        else $error("LED active with no fault");

endmodule

// ---- verif/tb_top.sv ----
// Self-checking bench for the fault status reporting block
`timescale 1ns/1ps
module tb_top;
    import fsr_pkg::*;
    typedef struct packed {
        logic rd;
        logic [31:0] data;
        logic err;
    } fsr_exp_t;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    fsr_apb_req_t apb_req = '0;
    fsr_apb_rsp_t apb_rsp;
    logic [63:0] fault_detect = '0;
    logic [15:0] fault_actions;
    logic led_out;
    logic [7:0] led_code;
    fsr_exp_t exp_q[$];
    fsr_exp_t e;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;
    // Implemented bits of each status word in the non-pump build
    logic [7:0] word_mask [8] = '{8'hFF, 8'hDF, 8'hFF, 8'hFF, 8'hFF, 8'h54, 8'hFE, 8'h08};
    logic [15:0] act_w [16];
    logic [15:0] user_w;
    logic [15:0] act_exp;
    fsr_top #(.PUMP_VARIANT(1'b0), .TICK_CYCLES(4)) uut (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .apb_req(apb_req),
        .apb_rsp(apb_rsp),
        .fault_detect(fault_detect),
        .fault_actions(fault_actions),
        .led_out(led_out),
        .led_code(led_code)
    );
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic fail(input string msg);
        mismatches++;
        $display("wrong value at %0t: %s", $time, msg);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            fail(msg);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Request is held until pready is sampled high; the monitor judges the answer
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd, input logic [31:0] rexp,
                       input logic err);
        exp_q.push_back('{rd: !wr, data: rexp, err: err});
        @(posedge sys_clk);
        apb_req.psel <= 1'b1;
        apb_req.pwrite <= wr;
        apb_req.paddr <= addr;
        apb_req.pwdata <= wd;
        apb_req.pstrb <= 4'hF;
        @(posedge sys_clk);
        apb_req.penable <= 1'b1;
        // No cycle count assumed here; only the bench timeout ends a hung wait
        do begin
            @(posedge sys_clk);
        end while (apb_rsp.pready !== 1'b1);
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] addr, input logic [31:0] wd, input logic err);
        apb(1'b1, addr, wd, 32'h0000_0000, err);
    endtask
    task automatic rd(input logic [11:0] addr, input logic [31:0] rexp, input logic err);
        apb(1'b0, addr, 32'h0000_0000, rexp, err);
    endtask
    task automatic wait_led(input logic [7:0] code);
        int n;
        n = 0;
        while (led_code !== code && n < 3000) begin
            @(posedge sys_clk);
            n++;
        end
        chk({24'h0, led_code}, {24'h0, code}, "led code");
        n = 0;
        while (code != 8'h00 && led_out !== 1'b1 && n < 100) begin
            @(posedge sys_clk);
            n++;
        end
        chk({31'h0, led_out}, {31'h0, code != 8'h00}, "led flash");
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles > 40000) begin
            fail("timeout");
            end_of_test();
        end
        if (apb_rsp.pready === 1'b1) begin
            if (exp_q.size() == 0) begin
                fail("unexpected pready");
            end else begin
                e = exp_q.pop_front();
                chk({31'h0, apb_rsp.pslverr}, {31'h0, e.err}, "pslverr");
                if (e.rd) begin
                    chk(apb_rsp.prdata, e.data, "prdata");
                end
            end
        end
    end
    initial begin
        void'($urandom(32'hB220));
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'b1;
        for (int r = 0; r < 3; r++) begin
            @(posedge sys_clk);
            fault_detect <= (r == 0) ? '1 : {$urandom, $urandom};
            repeat (2) @(posedge sys_clk);
            for (int w = 0; w < 8; w++) begin
                rd(12'(4 * w), {24'h0, fault_detect[8*w +: 8] & word_mask[w]}, 1'b0);
            end
        end
        wr(12'h004, 32'hFFFF_FFFF, 1'b0);
        rd(12'h004, {24'h0, fault_detect[15:8] & word_mask[1]}, 1'b0);
        rd(12'h002, 32'h0000_0000, 1'b1);
        rd(12'h080, 32'h0000_0000, 1'b1);
        wr(12'h0FC, 32'h0000_0001, 1'b1);
        user_w = 16'($urandom);
        wr(12'h020, {24'($urandom), user_w[7:0]}, 1'b0);
        wr(12'h024, {24'($urandom), user_w[15:8]}, 1'b0);
        rd(12'h020, {24'h0, user_w[7:0]}, 1'b0);
        rd(12'h024, {24'h0, user_w[15:8]}, 1'b0);
        repeat (2) @(posedge sys_clk);
        chk({16'h0, fault_actions}, 32'h0000_0000, "actions without words");
        act_exp = '0;
        for (int k = 0; k < 16; k++) begin
            act_w[k] = 16'($urandom);
            wr(12'(12'h040 + 4 * k), {16'($urandom), act_w[k]}, 1'b0);
            rd(12'(12'h040 + 4 * k), {16'h0, act_w[k]}, 1'b0);
            if (user_w[k]) begin
                act_exp |= act_w[k];
            end
        end
        repeat (2) @(posedge sys_clk);
        chk({16'h0, fault_actions}, {16'h0, act_exp}, "merged actions");
        for (int k = 0; k < 16; k++) begin
            user_w = 16'h0001 << k;
            wr(12'h020, {24'h0, user_w[7:0]}, 1'b0);
            wr(12'h024, {24'h0, user_w[15:8]}, 1'b0);
            repeat (2) @(posedge sys_clk);
            chk({16'h0, fault_actions}, {16'h0, act_w[k]}, "single action");
        end
        wr(12'h024, 32'h0000_0000, 1'b0);
        fault_detect <= '0;
        wr(12'h020, 32'h0000_0002, 1'b0);
        wait_led(8'h34);
        rd(12'h020, 32'h0000_0002, 1'b0);
        wr(12'h020, 32'h0000_0000, 1'b0);
        wr(12'h024, 32'h0000_0002, 1'b0);
        wait_led(8'h3D);
        wr(12'h024, 32'h0000_0000, 1'b0);
        fault_detect <= 64'h0000_0000_0000_0100;
        wait_led(8'h2F);
        fault_detect <= '0;
        wait_led(8'h00);
        chk({16'h0, fault_actions}, 32'h0000_0000, "actions cleared");
        repeat (4) @(posedge sys_clk);
        end_of_test();
    end
endmodule
